// ### pkg/ksg_pkg.sv
// Purpose: shared constants and types of the key slot access guard
// Assumes: 32-bit register port, 12-bit byte addresses into the config area
// Notes: config area storage is flash emulation held inside the guard
package ksg_pkg;
    // slot geometry
    localparam int unsigned SLOT_COUNT = 128;
    localparam int unsigned KEY_WORDS = 4;
    localparam int unsigned OTP_WORDS = 64;
    localparam int unsigned VAL_WORDS = SLOT_COUNT * KEY_WORDS;
    // register offsets on the register port
    localparam logic [11:0] REG_TASK_PUSH = 12'h000;
    localparam logic [11:0] REG_EV_PUSHED = 12'h100;
    localparam logic [11:0] REG_EV_REVOKED = 12'h104;
    localparam logic [11:0] REG_EV_ERROR = 12'h108;
    localparam logic [11:0] REG_STATUS = 12'h40C;
    localparam logic [11:0] REG_SLOT_SELECT = 12'h500;
    // status field positions
    localparam int unsigned ST_SELECTED_BIT = 0;
    localparam int unsigned ST_BLOCKED_BIT = 1;
    // config area map (byte addresses)
    localparam logic [11:0] CFG_OTP_END = 12'h100;
    localparam logic [11:0] CFG_ERASE_LOCK = 12'h200;
    localparam logic [1:0] CFG_HDR_TAG = 2'h1;
    // reset and fill values
    localparam logic [31:0] SELECT_RESET = 32'h00000000;
    localparam logic [7:0] SLOT_ID_MAX = 8'h80;
    localparam logic [31:0] BLOCKED_FILL = 32'hDEADDEAD;
    localparam logic [31:0] ERASED_WORD = 32'hFFFFFFFF;
    localparam logic [15:0] ERASED_HALF = 16'hFFFF;
    localparam logic [31:0] NO_DEST = 32'hFFFFFFFF;
    localparam logic [31:0] APB_WORD_STEP = 32'h00000004;
    // arbitrary value, chosen freely for the erase lock word
    localparam logic [31:0] ERASE_LOCK_KEY = 32'h5A5AC3C3;
    // permission field positions in the header perm word
    localparam int unsigned PERM_WRITE_BIT = 0;
    localparam int unsigned PERM_READ_BIT = 1;
    localparam int unsigned PERM_PUSH_BIT = 2;
    localparam int unsigned PERM_STATE_BIT = 3;
    localparam logic [3:0] PERM_ERASED = 4'hF;

    // cpu access into the config area
    typedef struct packed {
        logic req;
        logic write;
        logic secure;
        logic [11:0] addr;
        logic [31:0] wdata;
    } ksg_cpu_req_t;

    // secure apb master request
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } ksg_apb_req_t;

    // push sequencer states, gray along idle-setup-access
    typedef enum logic [1:0] {
        PUSH_IDLE = 2'b00,
        PUSH_SETUP = 2'b01,
        PUSH_ACCESS = 2'b11
    } ksg_push_state_t;
endpackage : ksg_pkg

// ### design/ksg_guard.sv
// Purpose: access guard for otp and key slot storage with secure apb key push
// Assumes: one clock, cpu answer one cycle after request, inputs synchronous
// Notes: storage arrays emulate flash and are kept across reset
// Notes: a blocked access changes nothing but the status flags
`timescale 1ns/10ps
module ksg_guard
    import ksg_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic [11:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    input wire ksg_cpu_req_t CPU_REQ,
    output logic [31:0] CPU_RDATA,
    output logic CPU_RESP_VALID,
    output logic CPU_BLOCKED,
    output ksg_apb_req_t APB_REQ,
    input wire logic APB_PREADY,
    input wire logic APB_PSLVERR,
    input wire logic FULL_ERASE_REQ_INT,
    input wire logic FULL_ERASE_REQ_EXT,
    output logic ERASE_LOCKED,
    output logic EV_PUSHED,
    output logic EV_REVOKED,
    output logic EV_ERROR
);
    // emulated flash contents, no reset: they persist like the real page
    logic [31:0] otp_mem [0:OTP_WORDS-1]; // otp words
    logic [31:0] hdr_dest [0:SLOT_COUNT-1]; // apb destination per slot
    logic [3:0] hdr_perm [0:SLOT_COUNT-1]; // state/push/read/write bits
    logic [31:0] key_val [0:VAL_WORDS-1]; // four value words per slot
    logic [31:0] lock_word; // erase lock word

    // erased page at power up
    // reset leaves the page alone, like a real flash page
    initial
    begin
        for (int i = 0; i < OTP_WORDS; i++)
        begin
            otp_mem[i] = ERASED_WORD;
        end
        for (int i = 0; i < SLOT_COUNT; i++)
        begin
            hdr_dest[i] = NO_DEST;
            hdr_perm[i] = PERM_ERASED;
        end
        for (int i = 0; i < VAL_WORDS; i++)
        begin
            key_val[i] = ERASED_WORD;
        end
        lock_word = ERASED_WORD;
    end

    // control registers
    logic [7:0] sel_r; // selected slot id, 0 = none
    logic [1:0] status_r; // selected and blocked flags
    logic ev_pushed_r;
    logic ev_revoked_r;
    logic ev_error_r;
    ksg_push_state_t push_state_r;
    logic [6:0] push_slot_r; // slot latched for the push
    logic [1:0] push_idx_r; // value word being pushed

    // the map is decoded from the address alone; req, write and secure
    // only qualify the result, so a refused access still decodes fully
    // address decode of the cpu access
    wire [11:0] a = CPU_REQ.addr;
    wire in_otp = (a < CFG_OTP_END);
    wire in_lock = (a == CFG_ERASE_LOCK);
    wire in_hdr = (a[11:10] == CFG_HDR_TAG);
    wire in_val = a[11];
    wire [5:0] otp_idx = a[7:2];
    wire [6:0] hdr_slot = a[9:3];
    wire hdr_is_perm = a[2];
    wire [6:0] val_slot = a[10:4];
    wire [8:0] val_idx = {a[10:4], a[3:2]};
    wire [31:0] wd = CPU_REQ.wdata;

    // slot matching against the selection
    // ids are one-based: id 0 selects nothing and never matches
    wire sel_valid = (sel_r != 8'h00);
    wire [6:0] sel_slot = 7'(sel_r - 8'h01);
    wire hdr_match = sel_valid && (hdr_slot == sel_slot);
    wire val_match = sel_valid && (val_slot == sel_slot);
    wire [3:0] val_perm = hdr_perm[val_slot];
    wire [3:0] hdrw_perm = hdr_perm[hdr_slot];

    // otp halfword checks
    // a halfword may change only while it still reads as erased, or when
    // the write leaves it at all ones, which the and below makes harmless
    wire [31:0] otp_old = otp_mem[otp_idx];
    wire hi_ok = (wd[31:16] == ERASED_HALF) || (otp_old[31:16] == ERASED_HALF);
    wire lo_ok = (wd[15:0] == ERASED_HALF) || (otp_old[15:0] == ERASED_HALF);
    wire otp_wr_ok = hi_ok && lo_ok;

    // permission of the access in hand
    // revoked slots lose read and push, yet keep the write bit
    wire val_rd_ok = val_match && val_perm[PERM_STATE_BIT] && val_perm[PERM_READ_BIT];
    wire val_wr_ok = val_match && val_perm[PERM_WRITE_BIT];
    wire hdr_wr_ok = hdr_match && hdrw_perm[PERM_WRITE_BIT];

    // allowed flags: every non-secure access is refused
    wire sec = CPU_REQ.secure;
    wire w = CPU_REQ.write;
    wire acc_ok = sec && (w ? ((in_otp && otp_wr_ok) || in_lock || (in_hdr && hdr_wr_ok)
                             || (in_val && val_wr_ok))
                            : (in_otp || in_lock || in_hdr || (in_val && val_rd_ok)));
    wire mapped = in_otp || in_lock || in_hdr || in_val;
    wire acc_blocked = CPU_REQ.req && mapped && !acc_ok;
    wire acc_good = CPU_REQ.req && mapped && acc_ok;
    wire do_wr = acc_good && w;
    wire slot_hit = acc_good && ((in_hdr && hdr_match) || (in_val && val_match));

    // read data of the cpu access
    // blocked reads never expose stored data, only the fill word
    wire [31:0] hdr_word = hdr_is_perm ? {28'h0, hdr_perm[hdr_slot]} : hdr_dest[hdr_slot];
    wire [31:0] raw_rd = in_otp ? otp_old :
                         in_lock ? lock_word :
                         in_hdr ? hdr_word :
                         in_val ? key_val[val_idx] : 32'h00000000;
    wire [31:0] cpu_rd_nxt = acc_blocked ? BLOCKED_FILL : raw_rd;

    // full erase gate
    // only the exact lock word locks; any other value leaves erase open
    wire locked = (lock_word == ERASE_LOCK_KEY);
    wire erase_go = (FULL_ERASE_REQ_INT || FULL_ERASE_REQ_EXT) && !locked;

    // storage writes, blocked writes never reach here
    always @(posedge REF_CLK)
    begin
        if (erase_go)
        begin
            // whole page back to erased, lock word included
            for (int i = 0; i < OTP_WORDS; i++)
            begin
                otp_mem[i] <= ERASED_WORD;
            end
            for (int i = 0; i < SLOT_COUNT; i++)
            begin
                hdr_dest[i] <= NO_DEST;
                hdr_perm[i] <= PERM_ERASED;
            end
            for (int i = 0; i < VAL_WORDS; i++)
            begin
                key_val[i] <= ERASED_WORD;
            end
            lock_word <= ERASED_WORD;
        end
        else if (do_wr)
        begin
            if (in_otp)
            begin
                // bits can only fall, as in flash
                otp_mem[otp_idx] <= otp_old & wd;
            end
            else if (in_lock)
            begin
                // any word may be stored; only the key locks
                lock_word <= wd;
            end
            else if (in_hdr && hdr_is_perm)
            begin
                // permission word of the selected slot
                hdr_perm[hdr_slot] <= wd[3:0];
            end
            else if (in_hdr)
            begin
                // push destination of the selected slot
                hdr_dest[hdr_slot] <= wd;
            end
            else
            begin
                key_val[val_idx] <= wd;
            end
        end
    end

    // register port decode
    // events clear on a zero in bit 0; writing a one has no effect
    wire wr_task = REG_WR && (REG_ADDR == REG_TASK_PUSH);
    wire wr_sel = REG_WR && (REG_ADDR == REG_SLOT_SELECT);
    wire clr_pushed = REG_WR && (REG_ADDR == REG_EV_PUSHED) && !REG_WDATA[0];
    wire clr_revoked = REG_WR && (REG_ADDR == REG_EV_REVOKED) && !REG_WDATA[0];
    wire clr_error = REG_WR && (REG_ADDR == REG_EV_ERROR) && !REG_WDATA[0];
    // an out-of-range id stores zero and flags blocked
    wire sel_bad = wr_sel && (REG_WDATA > {24'h0, SLOT_ID_MAX});
    wire [7:0] sel_nxt = wr_sel ? (sel_bad ? 8'h00 : REG_WDATA[7:0]) : sel_r;

    // push start checks on the selected slot
    // exactly one outcome per task write with bit 0 set while idle; revoked is tested first
    wire push_idle = (push_state_r == PUSH_IDLE);
    wire task_go = wr_task && REG_WDATA[0] && push_idle;
    wire [3:0] sel_perm = hdr_perm[sel_slot];
    wire sel_dest_none = (hdr_dest[sel_slot] == NO_DEST);
    wire start_none = task_go && !sel_valid;
    wire start_revoked = task_go && sel_valid && !sel_perm[PERM_STATE_BIT];
    wire start_bad = task_go && sel_valid && sel_perm[PERM_STATE_BIT]
                     && (sel_dest_none || !sel_perm[PERM_PUSH_BIT]
                         || (sel_perm == PERM_ERASED));
    wire start_ok = task_go && sel_valid && !start_revoked && !start_bad;

    // apb completion
    // an error answer ends the push at once, leaving words unsent
    wire apb_done = (push_state_r == PUSH_ACCESS) && APB_PREADY;
    wire apb_err = apb_done && APB_PSLVERR;
    wire apb_last = apb_done && !APB_PSLVERR && (push_idx_r == 2'(KEY_WORDS - 1));
    wire apb_more = apb_done && !APB_PSLVERR && !apb_last;
    wire [8:0] push_word = {push_slot_r, push_idx_r};

    // status: set wins over the clear by a select write
    // so a refused access beside a select write still shows as blocked
    wire [1:0] status_set = {acc_blocked || sel_bad, slot_hit};
    wire [1:0] status_nxt = status_set | (wr_sel ? 2'b00 : status_r);

    // event flags: set wins over software clear
    // a flag stays up until software writes a zero to it
    wire pushed_nxt = apb_last || (ev_pushed_r && !clr_pushed);
    wire revoked_nxt = start_revoked || (ev_revoked_r && !clr_revoked);
    wire error_nxt = start_none || start_bad || apb_err || (ev_error_r && !clr_error);

    // register read mux
    // reads of unmapped offsets and idle cycles give zero
    wire [31:0] reg_rd_nxt = !REG_RD ? 32'h00000000 :
                             (REG_ADDR == REG_EV_PUSHED) ? {31'h0, ev_pushed_r} :
                             (REG_ADDR == REG_EV_REVOKED) ? {31'h0, ev_revoked_r} :
                             (REG_ADDR == REG_EV_ERROR) ? {31'h0, ev_error_r} :
                             (REG_ADDR == REG_STATUS) ? {30'h0, status_r} :
                             (REG_ADDR == REG_SLOT_SELECT) ? {24'h0, sel_r} : 32'h00000000;

    // selection, status and events
    // only control state is reset; storage keeps its contents
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            sel_r <= SELECT_RESET[7:0];
            status_r <= 2'h0;
            ev_pushed_r <= 1'b0;
            ev_revoked_r <= 1'b0;
            ev_error_r <= 1'b0;
        end
        else
        begin
            sel_r <= sel_nxt;
            status_r <= status_nxt;
            ev_pushed_r <= pushed_nxt;
            ev_revoked_r <= revoked_nxt;
            ev_error_r <= error_nxt;
        end
    end

    // answers on the register port and cpu port
    // every port answer stands one cycle and falls back to zero; ERASE_LOCKED holds while the lock word matches
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            REG_RDATA <= 32'h00000000;
            CPU_RDATA <= 32'h00000000;
            CPU_RESP_VALID <= 1'b0;
            CPU_BLOCKED <= 1'b0;
            ERASE_LOCKED <= 1'b0;
        end
        else
        begin
            REG_RDATA <= reg_rd_nxt;
            CPU_RDATA <= (CPU_REQ.req && !w) ? cpu_rd_nxt : 32'h00000000;
            CPU_RESP_VALID <= CPU_REQ.req;
            CPU_BLOCKED <= acc_blocked;
            ERASE_LOCKED <= locked;
        end
    end

    // event outputs mirror the flags
    assign EV_PUSHED = ev_pushed_r;
    assign EV_REVOKED = ev_revoked_r;
    assign EV_ERROR = ev_error_r;

    // push sequencer: four apb writes of the latched slot
    // the slot is latched at start, so a new select cannot redirect it
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            push_state_r <= PUSH_IDLE;
            push_slot_r <= 7'h00;
            push_idx_r <= 2'h0;
            APB_REQ <= '0;
        end
        else
        begin
            case (push_state_r)
                PUSH_IDLE:
                begin
                    if (start_ok)
                    begin
                        // first word setup phase
                        push_state_r <= PUSH_SETUP;
                        push_slot_r <= sel_slot;
                        push_idx_r <= 2'h0;
                        APB_REQ.psel <= 1'b1;
                        APB_REQ.penable <= 1'b0;
                        APB_REQ.pwrite <= 1'b1;
                        APB_REQ.paddr <= hdr_dest[sel_slot];
                        APB_REQ.pwdata <= key_val[{sel_slot, 2'h0}];
                    end
                end
                PUSH_SETUP:
                begin
                    // setup lasts exactly one cycle
                    // enter access phase
                    push_state_r <= PUSH_ACCESS;
                    APB_REQ.penable <= 1'b1;
                end
                PUSH_ACCESS:
                begin
                    // without ready every signal holds through the wait states
                    if (apb_more)
                    begin
                        // next word, address steps by one word
                        push_state_r <= PUSH_SETUP;
                        push_idx_r <= push_idx_r + 2'h1;
                        APB_REQ.penable <= 1'b0;
                        APB_REQ.paddr <= APB_REQ.paddr + APB_WORD_STEP;
                        APB_REQ.pwdata <= key_val[push_word + 9'h001];
                    end
                    else if (apb_done)
                    begin
                        // last word or error ends the push
                        push_state_r <= PUSH_IDLE;
                        APB_REQ <= '0;
                    end
                end
                default:
                begin
                    push_state_r <= PUSH_IDLE;
                    APB_REQ <= '0;
                end
            endcase
        end
    end
endmodule : ksg_guard

// ### test/ksg_apb_slave.sv
// Purpose: apb slave standing in for a crypto key register bank
// Assumes: ready only in access phase, wait states set by the bench
// Notes: keeps the last word per offset for the bench to look at
`timescale 1ns/10ps
module ksg_apb_slave
    import ksg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire ksg_apb_req_t req,
    input wire logic [1:0] wait_n,
    input wire logic err,
    output logic pready,
    output logic pslverr
);
    logic [1:0] cnt_r; // wait cycles spent in access
    logic tog_r; // noise while no answer stands
    logic [31:0] addr_r [4]; // captured address per word
    logic [31:0] data_r [4]; // captured data per word
    // ready once the wait count is used up
    assign pready = req.psel && req.penable && cnt_r == wait_n;
    // error qualified by ready, changing pattern otherwise
    assign pslverr = pready ? err : tog_r;
    // wait counter and capture of written words
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_r <= 2'h0;
            tog_r <= 1'h0;
        end
        else
        begin
            tog_r <= ~tog_r;
            cnt_r <= (req.penable && !pready) ? cnt_r + 2'h1 : 2'h0;
            if (pready)
            begin
                addr_r[req.paddr[3:2]] <= req.paddr;
                data_r[req.paddr[3:2]] <= req.pwdata;
            end
        end
    end
endmodule : ksg_apb_slave

// ### test/ksg_guard_properties.sv
// Purpose: concurrent checks on the guard ports
// Assumes: one clock domain, asynchronous active-low reset
// Notes: attached to the guard by the bind below
`timescale 1ns/10ps
module ksg_guard_properties
    import ksg_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire ksg_cpu_req_t CPU_REQ,
    input wire logic [31:0] CPU_RDATA,
    input wire logic CPU_RESP_VALID,
    input wire logic CPU_BLOCKED,
    input wire ksg_apb_req_t APB_REQ,
    input wire logic APB_PREADY,
    input wire logic APB_PSLVERR,
    input wire logic EV_PUSHED,
    input wire logic EV_ERROR
);
    default clocking dcb @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_N);
    a_resp_follows: assert property (CPU_REQ.req |=> CPU_RESP_VALID)
        else $error("cpu answer missing");
    a_resp_only: assert property (!CPU_REQ.req |=> !CPU_RESP_VALID)
        else $error("cpu answer without request");
    a_nonsecure_blocked: assert property (CPU_REQ.req && !CPU_REQ.secure |=> CPU_BLOCKED)
        else $error("non-secure access let through");
    a_blocked_fill: assert property (CPU_REQ.req && !CPU_REQ.write |=>
        CPU_BLOCKED |-> CPU_RDATA == BLOCKED_FILL)
        else $error("blocked read without fill word");
    a_blocked_answer: assert property (CPU_BLOCKED |-> CPU_RESP_VALID)
        else $error("blocked flag outside answer");
    a_setup_first: assert property ($rose(APB_REQ.psel) |->
        !APB_REQ.penable ##1 APB_REQ.penable)
        else $error("apb setup phase wrong");
    a_apb_hold: assert property (APB_REQ.penable && !APB_PREADY |=> $stable(APB_REQ))
        else $error("apb request moved while waiting");
    a_word_step: assert property ($fell(APB_REQ.penable) && APB_REQ.psel |->
        APB_REQ.paddr == $past(APB_REQ.paddr) + APB_WORD_STEP)
        else $error("apb address step wrong");
    a_push_done: assert property ($fell(APB_REQ.psel) && !$past(APB_PSLVERR) |-> EV_PUSHED)
        else $error("pushed event missing");
    a_push_fail: assert property ($fell(APB_REQ.psel) && $past(APB_PSLVERR) |->
        ##[0:1] EV_ERROR)
        else $error("error event missing after slave error");
endmodule : ksg_guard_properties
bind ksg_guard ksg_guard_properties u_props (.REF_CLK(REF_CLK), .RST_N(RST_N),
    .CPU_REQ(CPU_REQ), .CPU_RDATA(CPU_RDATA), .CPU_RESP_VALID(CPU_RESP_VALID),
    .CPU_BLOCKED(CPU_BLOCKED), .APB_REQ(APB_REQ), .APB_PREADY(APB_PREADY),
    .APB_PSLVERR(APB_PSLVERR),
    .EV_PUSHED(EV_PUSHED), .EV_ERROR(EV_ERROR));

// ### test/tb.sv
// Purpose: self-checking bench for the key slot access guard
// Assumes: tasks start on a rising edge, answers taken 1 ns after
// Notes: far side apb is ksg_apb_slave; storage starts erased
`timescale 1ns/10ps
module tb
    import ksg_pkg::*;
;
    localparam logic W = 1'h1, R = 1'h0, S = 1'h1, N = 1'h0; // write/read, yes/no
    localparam logic [31:0] DEST = 32'h40001000; // key register bank base
    logic ref_clk = 1'h0, rst_n = 1'h0; // clock and reset
    logic [11:0] reg_addr = 12'h000; // register port
    logic [31:0] reg_wdata = 32'h00000000, reg_rdata;
    logic reg_wr = 1'h0, reg_rd = 1'h0;
    ksg_cpu_req_t cpu_req = '0; // cpu port
    logic [31:0] cpu_rdata, rd;
    logic cpu_valid, cpu_blk;
    ksg_apb_req_t apb_req; // apb link
    logic pready, pslverr, apb_err = 1'h0;
    logic [1:0] apb_wait = 2'h0;
    logic erase_int = 1'h0, erase_ext = 1'h0, erase_locked; // erase control
    logic ev_pushed, ev_revoked, ev_error; // event flags
    int n_errors = 0, checks_done = 0, i;
    ksg_guard u_dut (.REF_CLK(ref_clk), .RST_N(rst_n), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
        .CPU_REQ(cpu_req), .CPU_RDATA(cpu_rdata), .CPU_RESP_VALID(cpu_valid),
        .CPU_BLOCKED(cpu_blk), .APB_REQ(apb_req), .APB_PREADY(pready),
        .APB_PSLVERR(pslverr), .FULL_ERASE_REQ_INT(erase_int),
        .FULL_ERASE_REQ_EXT(erase_ext), .ERASE_LOCKED(erase_locked),
        .EV_PUSHED(ev_pushed), .EV_REVOKED(ev_revoked), .EV_ERROR(ev_error));
    ksg_apb_slave u_apb (.clk(ref_clk), .rst_n(rst_n), .req(apb_req), .wait_n(apb_wait),
        .err(apb_err), .pready(pready), .pslverr(pslverr));
    // free-running clock, 40 ns period
    initial
    begin
        forever #20 ref_clk = ~ref_clk;
    end
    // compare and count
    task automatic chk(input string what, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // register write, one-cycle strobe
    task automatic reg_w(input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'h0;
        reg_wdata <= ~d;
    endtask : reg_w
    // register read, data taken in the cycle after the strobe
    task automatic rx(input logic [11:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'h0;
        #1 chk("register", reg_rdata, exp);
    endtask : rx
    // one cpu access, answer and blocked flag checked
    task automatic cx(input logic w, s, input logic [11:0] a, input logic [31:0] d, er,
        input logic eb);
        @(posedge ref_clk);
        cpu_req <= {1'h1, w, s, a, d};
        @(posedge ref_clk);
        cpu_req <= {1'h0, ~w, ~s, ~a, ~d};
        #1 chk("cpu valid", {31'h00000000, cpu_valid}, 32'h00000001);
        chk("cpu blocked", {31'h00000000, cpu_blk}, {31'h00000000, eb});
        if (!w)
            chk("cpu read data", cpu_rdata, er);
    endtask : cx
    // clear events, start a push, wait for an event
    task automatic push(input logic [1:0] wt, input logic er, input logic [2:0] exp);
        apb_wait <= wt;
        apb_err <= er;
        reg_w(REG_EV_PUSHED, 32'h00000000);
        reg_w(REG_EV_REVOKED, 32'h00000000);
        reg_w(REG_EV_ERROR, 32'h00000000);
        reg_w(REG_TASK_PUSH, 32'h00000001);
        for (i = 0; i < 60 && !(ev_pushed || ev_revoked || ev_error); i++)
            @(posedge ref_clk);
        #1 chk("events", {29'h00000000, ev_pushed, ev_revoked, ev_error}, {29'h0, exp});
    endtask : push
    // verdict and end of run
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    // cut a hang short
    initial
    begin
        #200000;
        n_errors++;
        end_of_test();
    end
    // main sequence
    initial
    begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'h1;
        rx(REG_SLOT_SELECT, SELECT_RESET);
        chk("erase lock", {31'h00000000, erase_locked}, 32'h00000000);
        cx(R, S, 12'h400, 32'h0, NO_DEST, N);
        cx(R, N, 12'h400, 32'h0, BLOCKED_FILL, S);
        cx(R, S, 12'h800, 32'h0, BLOCKED_FILL, S);
        rx(REG_STATUS, 32'h00000002);
        $display("test access without selection done");
        reg_w(REG_SLOT_SELECT, 32'h00000001);
        rx(REG_STATUS, 32'h00000000);
        cx(R, S, 12'h800, 32'h0, ERASED_WORD, N);
        for (i = 0; i < 4; i++)
            cx(W, S, 12'h800 + 12'(4 * i), 32'hC0DE0000 + i, 32'h0, N);
        rx(REG_STATUS, 32'h00000001);
        cx(W, S, 12'h400, DEST, 32'h0, N);
        cx(W, S, 12'h404, 32'h0000000E, 32'h0, N);
        cx(W, S, 12'h800, 32'h00000000, 32'h0, S);
        cx(W, S, 12'h400, 32'h00000000, 32'h0, S);
        cx(R, S, 12'h800, 32'h0, 32'hC0DE0000, N);
        cx(R, S, 12'h400, 32'h0, DEST, N);
        cx(R, S, 12'h810, 32'h0, BLOCKED_FILL, S);
        $display("test slot setup done");
        push(2'h2, 1'h0, 3'h4);
        for (i = 0; i < 4; i++)
        begin
            chk("apb address", u_apb.addr_r[i], DEST + 32'(4 * i));
            chk("apb data", u_apb.data_r[i], 32'hC0DE0000 + i);
        end
        rx(REG_EV_PUSHED, 32'h00000001);
        push(2'h0, 1'h1, 3'h1);
        reg_w(REG_SLOT_SELECT, 32'h00000002);
        cx(W, S, 12'h408, DEST, 32'h0, N);
        push(2'h1, 1'h0, 3'h1);
        reg_w(REG_SLOT_SELECT, 32'h00000000);
        push(2'h0, 1'h0, 3'h1);
        $display("test push done");
        reg_w(REG_SLOT_SELECT, 32'h00000003);
        cx(W, S, 12'h410, DEST, 32'h0, N);
        cx(W, S, 12'h414, 32'h00000007, 32'h0, N);
        cx(R, S, 12'h820, 32'h0, BLOCKED_FILL, S);
        push(2'h0, 1'h0, 3'h2);
        reg_w(REG_SLOT_SELECT, 32'h000000C8);
        rx(REG_SLOT_SELECT, 32'h00000000);
        rx(REG_STATUS, 32'h00000002);
        reg_w(REG_SLOT_SELECT, 32'h00000000);
        $display("test revoke and select range done");
        cx(W, S, 12'h004, 32'hFFFFAABB, 32'h0, N);
        cx(W, S, 12'h004, 32'h1234FFFF, 32'h0, N);
        cx(R, S, 12'h004, 32'h0, 32'h1234AABB, N);
        cx(W, S, 12'h004, 32'h5678FFFF, 32'h0, S);
        cx(W, S, 12'h004, 32'hFFFF1111, 32'h0, S);
        cx(W, N, 12'h008, 32'h0000FFFF, 32'h0, S);
        cx(R, S, 12'h004, 32'h0, 32'h1234AABB, N);
        cx(R, S, 12'h008, 32'h0, ERASED_WORD, N);
        rx(REG_STATUS, 32'h00000002);
        $display("test otp done");
        for (i = 0; i < 2; i++)
        begin
            reg_w(REG_SLOT_SELECT, 32'h00000004 + i);
            cx(W, S, 12'h830 + 12'(16 * i), 32'hBEEF0000 + i, 32'h0, N);
            cx(R, S, 12'h830 + 12'(16 * i), 32'h0, 32'hBEEF0000 + i, N);
        end
        reg_w(REG_SLOT_SELECT, 32'h00000000);
        @(posedge ref_clk);
        erase_ext <= 1'h1;
        @(posedge ref_clk);
        erase_ext <= 1'h0;
        cx(R, S, 12'h004, 32'h0, ERASED_WORD, N);
        cx(W, S, 12'h004, 32'h1234AABB, 32'h0, N);
        $display("test split key and open erase done");
        cx(W, S, CFG_ERASE_LOCK, ERASE_LOCK_KEY, 32'h0, N);
        @(posedge ref_clk);
        erase_int <= 1'h1;
        erase_ext <= 1'h1;
        @(posedge ref_clk);
        erase_int <= 1'h0;
        erase_ext <= 1'h0;
        #1 chk("erase lock", {31'h00000000, erase_locked}, 32'h00000001);
        cx(R, S, 12'h004, 32'h0, 32'h1234AABB, N);
        $display("test erase lock done");
        end_of_test();
    end
endmodule : tb
